// ===== gpxb_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module gpxb_periph_model #(
	parameter logic [7:0] OUT_PAT = 8'h04,
	parameter logic [7:0] OE_PAT = 8'h0c
) (
	// Clock
	input wire logic clock,
	// Pad controls from the crossbar
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pull_up,
	input wire logic [7:0] pin_pull_down,
	// Pad levels and peripheral drive
	output logic [7:0] pin_in,
	output logic [gpxb_pkg::NUM_DIGITAL*8-1:0] periph_out,
	output logic [gpxb_pkg::NUM_DIGITAL*8-1:0] periph_oe
);
	logic [7:0] float_r = 8'h55;

	////////////////////////////////////////////////////////////////////////
	// Floating pads toggle so a stale level never passes for a real one
	always_ff @(posedge clock) begin
		float_r <= ~float_r;
	end

	// Pad level: own driver, then pull resistor, else floating
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : pin_pull_up[i] ? 1'b1 :
				pin_pull_down[i] ? 1'b0 : float_r[i];
		end
	end

	// All peripherals share one pattern; drive is fixed at OUT_PAT under OE_PAT
	assign periph_out = {gpxb_pkg::NUM_DIGITAL{OUT_PAT}};
	assign periph_oe = {gpxb_pkg::NUM_DIGITAL{OE_PAT}};
endmodule
`default_nettype wire

// ===== gpxb_pin_crossbar.sv
`timescale 1ns/10ps
`default_nettype none
module gpxb_pin_crossbar #(
	parameter int NP = 8,
	parameter logic [gpxb_pkg::NUM_DIGITAL*8-1:0] REQ_MASK =
		48'h48_60_7c_3c_1c_03,
	parameter logic [7:0] LFOSC_ANA_MASK = 8'h03
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Peripheral requests, one enable per digital peripheral
	input wire logic [gpxb_pkg::NUM_DIGITAL-1:0] periph_en,
	input wire logic [gpxb_pkg::NUM_DIGITAL*8-1:0] periph_out,
	input wire logic [gpxb_pkg::NUM_DIGITAL*8-1:0] periph_oe,
	input wire logic lfosc_analog_mode,
	input wire logic converter_en,
	input wire logic comparator_en,
	input wire logic [2:0] converter_channel_select,
	input wire logic converter_reference_select,
	input wire logic [2:0] converter_reference_pin,
	// Alternate default transmitter, idles high
	input wire logic [7:0] alt_tx,
	// Pad side
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_in_en,
	output logic [7:0] pin_pull_up,
	output logic [7:0] pin_pull_down,
	output logic [7:0] pin_high_drive,
	output logic [7:0] pin_analog_sel,
	output logic [7:0] pin_analog_conv,
	// Receivers
	output logic [7:0] alt_rx,
	output logic [7:0] periph_in
);

	localparam int ND = gpxb_pkg::NUM_DIGITAL;
	////////////////////////////////////////////////////////////////////////
	// Bus handshake
	logic wait_r;
	logic acc;
	logic [7:0] port_data_r;
	logic [7:0] port_dir_r;
	logic [2:0] feat_addr_r;
	logic [7:0] high_drive_r;
	logic [1:0] in_feat_r [8];
	logic [7:0] level_r;
	logic [ND-1:0] grant_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	// One wait cycle per request, then a single-cycle acknowledge
	always_ff @(posedge clock) begin
		if (!rst_n)
			wait_r <= 1'b1;
		else if ((avs_read || avs_write) && wait_r)
			wait_r <= 1'b0;
		else
			wait_r <= 1'b1;
	end
	assign acc = !wait_r;

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (avs_address)
			gpxb_pkg::OFS_PORT_DATA: rdata_nxt[7:0] = port_data_r;
			gpxb_pkg::OFS_PORT_DIR: rdata_nxt[7:0] = port_dir_r;
			gpxb_pkg::OFS_PIN_FEAT: begin
				rdata_nxt[2:0] = feat_addr_r;
				rdata_nxt[4] = high_drive_r[feat_addr_r];
				rdata_nxt[6:5] = in_feat_r[feat_addr_r];
			end
			gpxb_pkg::OFS_PIN_LEVEL: rdata_nxt[7:0] = level_r;
			gpxb_pkg::OFS_GRANT: rdata_nxt[ND-1:0] = grant_r;
			gpxb_pkg::OFS_ANALOG: rdata_nxt[7:0] = pin_analog_sel;
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Data stands at the acknowledging edge
	always_ff @(posedge clock) begin
		if (!rst_n)
			rdata_r <= 32'h0000_0000;
		else if (avs_read && wait_r)
			rdata_r <= rdata_nxt;
	end
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;

	////////////////////////////////////////////////////////////////////////
	// Port-wide data and direction registers
	// Whole port in one access
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port_data_r <= gpxb_pkg::RST_DATA;
			port_dir_r <= gpxb_pkg::RST_DIR;
		end else if (acc && avs_write) begin
			if (avs_address == gpxb_pkg::OFS_PORT_DATA)
				port_data_r <= avs_writedata[7:0];
			if (avs_address == gpxb_pkg::OFS_PORT_DIR)
				port_dir_r <= avs_writedata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-pin feature storage
	logic [2:0] wr_pin;
	logic wr_feat;
	logic [1:0] wr_code;
	assign wr_pin = avs_writedata[gpxb_pkg::FEAT_ADDR_LSB+:3];
	assign wr_code = avs_writedata[gpxb_pkg::FEAT_CODE_LSB+:2];
	assign wr_feat = acc && avs_write &&
		(avs_address == gpxb_pkg::OFS_PIN_FEAT);

	// Pin address is kept so a later read sees the same pin
	always_ff @(posedge clock) begin
		if (!rst_n)
			feat_addr_r <= 3'h0;
		else if (wr_feat)
			feat_addr_r <= wr_pin;
	end

	// Only the addressed pin changes, so writes accumulate
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			high_drive_r <= {8{gpxb_pkg::RST_HIGH_DRIVE}};
			for (int i = 0; i < 8; i++)
				in_feat_r[i] <= gpxb_pkg::RST_IN_FEAT;
		end else if (wr_feat) begin
			if (avs_writedata[gpxb_pkg::FEAT_SIDE_BIT])
				high_drive_r[wr_pin] <= (wr_code == gpxb_pkg::OUT_HIGH);
			else
				in_feat_r[wr_pin] <= wr_code;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Digital arbitration
	logic [ND-1:0] dig_en;
	logic [ND-1:0] grant_nxt;
	logic [7:0] higher;
	// Oscillator in analog mode makes no digital request
	always_comb begin
		dig_en = periph_en;
		dig_en[gpxb_pkg::PER_LFOSC] = periph_en[gpxb_pkg::PER_LFOSC] &&
			!lfosc_analog_mode;
	end

	// Enabled higher peripherals block a whole request, even if ungranted
	always_comb begin
		higher = 8'h00;
		grant_nxt = '0;
		for (int p = 0; p < ND; p++) begin
			if (dig_en[p] && ((REQ_MASK[p*8+:8] & higher) == 8'h00))
				grant_nxt[p] = 1'b1;
			if (dig_en[p])
				higher = higher | REQ_MASK[p*8+:8];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			grant_r <= '0;
		else
			grant_r <= grant_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Analog selection
	logic [7:0] lf_ana;
	logic [7:0] conv_ana;
	logic [7:0] conv_win;
	// Comparator reuses converter selects, so both share one column
	always_comb begin
		lf_ana = (periph_en[gpxb_pkg::PER_LFOSC] && lfosc_analog_mode) ?
			LFOSC_ANA_MASK : 8'h00;
		conv_ana = 8'h00;
		if (converter_en || comparator_en) begin
			conv_ana[converter_channel_select] = 1'b1;
			if (converter_reference_select)
				conv_ana[converter_reference_pin] = 1'b1;
		end
		conv_win = conv_ana & ~lf_ana;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_analog_sel <= 8'h00;
			pin_analog_conv <= 8'h00;
		end else begin
			pin_analog_sel <= lf_ana | conv_win;
			pin_analog_conv <= conv_win;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-pin output mux
	logic [7:0] own_nxt;
	logic [7:0] d_out_nxt;
	logic [7:0] d_oe_nxt;
	// Granted masks are disjoint, so OR-ing selects the single owner
	always_comb begin
		own_nxt = 8'h00;
		d_out_nxt = 8'h00;
		d_oe_nxt = 8'h00;
		for (int p = 0; p < ND; p++) begin
			if (grant_nxt[p]) begin
				own_nxt = own_nxt | REQ_MASK[p*8+:8];
				d_out_nxt = d_out_nxt | (REQ_MASK[p*8+:8] & periph_out[p*8+:8]);
				d_oe_nxt = d_oe_nxt | (REQ_MASK[p*8+:8] & periph_oe[p*8+:8]);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			// Analog selection never touches the digital path
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					pin_out[g] <= 1'b1;
					pin_oe[g] <= 1'b0;
					pin_in_en[g] <= 1'b1;
					pin_pull_up[g] <= 1'b0;
					pin_pull_down[g] <= 1'b0;
					pin_high_drive[g] <= 1'b0;
					alt_rx[g] <= 1'b1;
				end else if (own_nxt[g]) begin
					pin_out[g] <= d_out_nxt[g];
					pin_oe[g] <= d_oe_nxt[g];
					pin_in_en[g] <= 1'b1;
					pin_pull_up[g] <= 1'b0;
					pin_pull_down[g] <= 1'b0;
					pin_high_drive[g] <= 1'b0;
					alt_rx[g] <= 1'b1;
				end else begin
					pin_out[g] <= port_data_r[g] & alt_tx[g];
					pin_oe[g] <= port_dir_r[g];
					pin_in_en[g] <= in_feat_r[g] != gpxb_pkg::IN_BUF_OFF;
					pin_pull_up[g] <= in_feat_r[g] == gpxb_pkg::IN_PULL_UP;
					pin_pull_down[g] <= in_feat_r[g] == gpxb_pkg::IN_PULL_DOWN;
					pin_high_drive[g] <= high_drive_r[g];
					alt_rx[g] <= port_dir_r[g] | pin_in[g];
				end
			end
		end
	endgenerate

	// Input levels to software and peripherals
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			level_r <= 8'h00;
			periph_in <= 8'h00;
		end else begin
			level_r <= pin_in;
			periph_in <= pin_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest;
	endsequence
	chk_bus_ack: assert property (@(posedge clock)
		disable iff (!rst_n) s_req |=> s_ack ##1 avs_waitrequest)
		else $error("bus acknowledge not after one wait cycle");
	chk_dir_write: assert property (@(posedge clock)
		disable iff (!rst_n) (avs_write && !avs_waitrequest &&
		avs_address == gpxb_pkg::OFS_PORT_DIR) |=>
		port_dir_r == $past(avs_writedata[7:0]))
		else $error("direction write lost");
	chk_reset_input: assert property (@(posedge clock)
		!rst_n |=> pin_oe == 8'h00)
		else $error("pin driving after reset");
	chk_default_oe: assert property (@(posedge clock)
		disable iff (!rst_n) (grant_nxt == '0) |=>
		pin_oe == $past(port_dir_r))
		else $error("default direction not applied");
	chk_and_out: assert property (@(posedge clock)
		disable iff (!rst_n) (grant_nxt == '0) |=>
		pin_out == ($past(port_data_r) & $past(alt_tx)))
		else $error("default output not AND of sources");
	chk_full_grant: assert property (@(posedge clock)
		disable iff (!rst_n) dig_en[gpxb_pkg::PER_LFOSC] |=>
		grant_r[gpxb_pkg::PER_LFOSC] &&
		pin_oe[1:0] == $past(periph_oe[1:0]))
		else $error("top priority request not granted");
	chk_no_partial: assert property (@(posedge clock)
		disable iff (!rst_n)
		(dig_en[gpxb_pkg::PER_SPI_MASTER] && dig_en[gpxb_pkg::PER_SPI_SLAVE])
		|=> !grant_r[gpxb_pkg::PER_SPI_SLAVE])
		else $error("conflicting lower request granted");
	chk_analog_sel: assert property (@(posedge clock)
		disable iff (!rst_n) (converter_en || comparator_en) &&
		!(periph_en[gpxb_pkg::PER_LFOSC] && lfosc_analog_mode) |=>
		pin_analog_sel[$past(converter_channel_select)])
		else $error("selected analog channel not connected");
	chk_feat_keep: assert property (@(posedge clock)
		disable iff (!rst_n) wr_feat &&
		!avs_writedata[gpxb_pkg::FEAT_SIDE_BIT] && wr_pin != 3'h0
		|=> in_feat_r[0] == $past(in_feat_r[0]))
		else $error("unaddressed pin feature changed");
endmodule
`default_nettype wire

// ===== gpxb_pkg.sv
`default_nettype none
package gpxb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the register bus
	localparam logic [7:0] OFS_PORT_DATA = 8'h00;
	localparam logic [7:0] OFS_PORT_DIR = 8'h04;
	localparam logic [7:0] OFS_PIN_FEAT = 8'h08;
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h0c;
	localparam logic [7:0] OFS_GRANT = 8'h10;
	localparam logic [7:0] OFS_ANALOG = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// Pin feature word layout: pin address, side select, feature code
	localparam int FEAT_ADDR_LSB = 0;
	localparam int FEAT_ADDR_W = 3;
	localparam int FEAT_SIDE_BIT = 3;
	localparam int FEAT_CODE_LSB = 4;
	localparam int FEAT_CODE_W = 2;

	// Output-side codes
	localparam logic [1:0] OUT_NORMAL = 2'h0;
	localparam logic [1:0] OUT_HIGH = 2'h1;
	// Input-side codes
	localparam logic [1:0] IN_NO_PULL = 2'h0;
	localparam logic [1:0] IN_PULL_UP = 2'h1;
	localparam logic [1:0] IN_PULL_DOWN = 2'h2;
	localparam logic [1:0] IN_BUF_OFF = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Reset values: every pin a digital input, buffer on, no pull
	localparam logic [7:0] RST_DATA = 8'hff;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [1:0] RST_IN_FEAT = IN_NO_PULL;
	localparam logic RST_HIGH_DRIVE = 1'b0;

	// Digital peripheral index, highest priority first
	localparam int PER_LFOSC = 0;
	localparam int PER_SPI_MASTER = 1;
	localparam int PER_SPI_SLAVE = 2;
	localparam int PER_DEBUG = 3;
	localparam int PER_TWO_WIRE = 4;
	localparam int PER_PWM = 5;
	localparam int NUM_DIGITAL = 6;

endpackage
`default_nettype wire

// ===== tb_gpxb_pin_crossbar.sv
`timescale 1ns/10ps
`default_nettype none
module tb_gpxb_pin_crossbar;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [5:0] periph_en = 6'h00;
	logic [47:0] periph_out, periph_oe;
	logic lfosc_analog_mode = 1'b0;
	logic converter_en = 1'b0;
	logic comparator_en = 1'b0;
	logic [2:0] converter_channel_select = 3'h0;
	logic converter_reference_select = 1'b0;
	logic [2:0] converter_reference_pin = 3'h0;
	logic [7:0] alt_tx = 8'hff;
	logic [7:0] pin_in, pin_out, pin_oe, pin_in_en, pin_pull_up;
	logic [7:0] pin_pull_down, pin_high_drive, pin_analog_sel;
	logic [7:0] pin_analog_conv, alt_rx, periph_in;
	logic [31:0] q;
	int error_cnt = 0;
	int comparisons = 0;

	////////////////////////////////////////////////////////////////////////
	// Design and far-side model
	gpxb_pin_crossbar gpxb_pin_crossbar_i (.clock, .rst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .periph_en, .periph_out, .periph_oe,
		.lfosc_analog_mode, .converter_en, .comparator_en,
		.converter_channel_select, .converter_reference_select,
		.converter_reference_pin, .alt_tx, .pin_in, .pin_out, .pin_oe,
		.pin_in_en, .pin_pull_up, .pin_pull_down, .pin_high_drive,
		.pin_analog_sel, .pin_analog_conv, .alt_rx, .periph_in);
	gpxb_periph_model gpxb_periph_model_i (.clock, .pin_out, .pin_oe,
		.pin_pull_up, .pin_pull_down, .pin_in, .periph_out, .periph_oe);

	// 100 MHz clock
	always #5 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// One bus access; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// No cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Pad outputs follow one edge after their cause; allow two
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		#1;
		chk(pin_oe, 8'h00);
		chk(pin_in_en, 8'hff);
		bus(1'b0, gpxb_pkg::OFS_PORT_DIR, 32'h0);
		chk(q, 32'h0);
	endtask

	// Six single-pin writes, one per feature, must accumulate
	task automatic t_feature;
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, gpxb_pkg::OFS_PIN_FEAT, 32'(i + 1) |
				(i < 2 ? 32'h8 : 32'h0) | (32'(i < 2 ? i : i - 2) << 4));
		end
		settle();
		chk(pin_high_drive, 8'h04);
		chk(pin_pull_up, 8'h10);
		chk(pin_pull_down, 8'h20);
		chk(pin_in_en, 8'hbf);
		bus(1'b0, gpxb_pkg::OFS_PIN_FEAT, 32'h0);
		chk(q, 32'h66);
	endtask

	// Low nibble outputs; bit 0 of the alternate sender pulls low
	task automatic t_gpio;
		@(posedge clock);
		alt_tx <= 8'hfe;
		bus(1'b1, gpxb_pkg::OFS_PORT_DIR, 32'h0f);
		bus(1'b1, gpxb_pkg::OFS_PORT_DATA, 32'ha5);
		settle();
		chk(pin_oe, 8'h0f);
		chk(pin_out & 8'h0f, 8'h04);
		chk(alt_rx & 8'h3f, 8'h1f);
		chk(periph_in & 8'h3f, 8'h14);
		bus(1'b0, gpxb_pkg::OFS_PORT_DIR, 32'h0);
		chk(q, 32'h0f);
		bus(1'b0, gpxb_pkg::OFS_PIN_LEVEL, 32'h0);
		chk(q & 32'h0f, 32'h04);
		bus(1'b0, 8'hfc, 32'h0);
		chk(q, 32'h0);
	endtask

	// Slave blocked by master; two-wire blocked by enabled slave
	task automatic t_digital;
		bus(1'b1, gpxb_pkg::OFS_PORT_DIR, 32'hf0);
		@(posedge clock);
		periph_en <= 6'h16;
		settle();
		bus(1'b0, gpxb_pkg::OFS_GRANT, 32'h0);
		chk(q, 32'h02);
		chk(pin_oe, 8'hec);
		chk(pin_out & 8'h1c, 8'h04);
		@(posedge clock);
		periph_en <= 6'h00;
		settle();
		chk(pin_oe, 8'hf0);
		@(posedge clock);
		periph_en <= 6'h30;
		settle();
		bus(1'b0, gpxb_pkg::OFS_GRANT, 32'h0);
		chk(q, 32'h10);
		chk(pin_oe, 8'h90);
		chk(pin_in_en, 8'hff);
		@(posedge clock);
		periph_en <= 6'h03;
		settle();
		bus(1'b0, gpxb_pkg::OFS_GRANT, 32'h0);
		chk(q, 32'h03);
		@(posedge clock);
		lfosc_analog_mode <= 1'b1;
		settle();
		bus(1'b0, gpxb_pkg::OFS_GRANT, 32'h0);
		chk(q, 32'h02);
		chk(pin_analog_sel, 8'h03);
	endtask

	// Oscillator analog claim beats converter on pin 1
	task automatic t_analog;
		@(posedge clock);
		// Direction and features were written before this enable
		converter_en <= 1'b1;
		converter_channel_select <= 3'h1;
		converter_reference_select <= 1'b1;
		converter_reference_pin <= 3'h6;
		settle();
		chk(pin_analog_sel, 8'h43);
		chk(pin_analog_conv, 8'h40);
		@(posedge clock);
		periph_en <= 6'h00;
		converter_en <= 1'b0;
		comparator_en <= 1'b1;
		converter_channel_select <= 3'h3;
		converter_reference_select <= 1'b0;
		settle();
		chk(pin_analog_conv, 8'h08);
		chk(pin_oe, 8'hf0);
		chk(pin_in_en, 8'hbf);
		bus(1'b0, gpxb_pkg::OFS_ANALOG, 32'h0);
		chk(q, 32'h08);
	endtask

	task automatic print_verdict;
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_feature();
		t_gpio();
		t_digital();
		t_analog();
		print_verdict();
	end

	// Watchdog, far beyond the fewer than one hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		print_verdict();
	end
endmodule
`default_nettype wire
